// ---- design/bac_input_control.sv ----
// Purpose: Digital control of a bridge transducer converter front end: coding, offset DAC, ranges, burnout,
//          reference selection, ac excitation and reference-loss handling.
// Assumes: Reference comparators are asynchronous pins; configuration and samples come from the clk_sys_i domain.
// Notes: One packed state struct, filled by one always_comb and registered by one always_ff.
`timescale 1ns/1ps

module bac_input_control import bac_pkg::*; (
    input wire logic clk_sys_i, // System clock, 200 MHz.
    input wire logic rst_n_i, // Asynchronous reset, active low.
    input wire bac_config_type config_i, // Host-programmed settings.
    input wire bac_ref_type ref_detect_i, // Asynchronous reference comparator pins.
    input wire logic signed [SAMPLE_W-1:0] sample_i, // Filtered sample.
    input wire logic sample_valid_i, // One-cycle pulse with each filtered sample.
    input wire logic result_read_i, // One-cycle pulse when the host reads the result.
    output logic [SAMPLE_W-1:0] result_o, // Conversion result register.
    output logic ready_n_o, // Low while an unread settled result is held.
    output logic ref_missing_o, // Reference-missing status flag.
    output logic [1:0] channel_o, // Input pair routed to the buffer.
    output logic [1:0] gain_o, // Amplifier range code.
    output logic [6:0] range_mv_o, // Nominal full-scale range in mV at nominal reference.
    output bac_dac_type dac_o, // Offset DAC sign and magnitude.
    output logic [11:0] dac_step_uv_o, // Offset DAC step size in uV.
    output logic burnout_source_o, // Source current switch.
    output logic burnout_sink_o, // Sink current switch.
    output logic high_reference_select_o, // Reference range select to the analog core.
    output logic excitation_clock_o, // Excitation clock, phase A.
    output logic excitation_clock_n_o // Excitation clock, phase B, nonoverlapping.
);

    typedef struct packed {
        bac_ref_type sync1;
        bac_ref_type sync2;
        logic ref_missing;
        logic [1:0] channel;
        logic [1:0] settle;
        logic ready_n;
        logic [SAMPLE_W-1:0] result;
        logic phase;
        logic exc_a;
        logic exc_b;
        logic burn_src;
        logic burn_snk;
        bac_dac_type dac;
        logic [1:0] gain;
        logic [6:0] range_mv;
        logic high_ref;
        logic [11:0] step_uv;
    } bac_state_type;

    bac_state_type state_reg;
    bac_state_type state_next;
    logic signed [SAMPLE_W-1:0] comp_sample;
    logic [SAMPLE_W-1:0] coded;

    // ****************************************************************
    // Chop reversal compensation and result coding
    // ****************************************************************

    always_comb begin
        comp_sample = sample_i;
        if (config_i.ac_mode && state_reg.phase) begin
            if (sample_i == {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
                comp_sample = {1'b0, {(SAMPLE_W-1){1'b1}}};
            end else begin
                comp_sample = -sample_i;
            end
        end
    end

    // Coding depends on the polarity bit, the word width and the reference-missing flag; no analog control reads it.
    bac_coder u_coder (
        .sample_i(comp_sample),
        .bipolar_i(config_i.bipolar),
        .wide_i(config_i.wide_word),
        .force_ones_i(state_reg.ref_missing),
        .code_o(coded)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************

    always_comb begin
        state_next = state_reg;
        state_next.sync1 = ref_detect_i;
        state_next.sync2 = state_reg.sync1;
        state_next.ref_missing = |state_reg.sync2;
        state_next.burn_src = config_i.burnout_enable;
        state_next.burn_snk = config_i.burnout_enable;
        state_next.dac = config_i.dac;
        state_next.high_ref = config_i.high_reference_select;
        state_next.step_uv = config_i.high_reference_select ? DAC_STEP_HIGH_UV : DAC_STEP_LOW_UV;
        state_next.gain = config_i.gain;
        state_next.range_mv = BASE_RANGE_MV << config_i.gain;
        if (result_read_i) begin
            state_next.ready_n = 1'b1;
        end
        if (config_i.channel != state_reg.channel) begin
            state_next.channel = config_i.channel;
            state_next.settle = SETTLE_SAMPLES;
            state_next.ready_n = 1'b1;
            state_next.phase = 1'b0;
        end else if (sample_valid_i) begin
            if (config_i.ac_mode) begin
                state_next.phase = ~state_reg.phase;
            end else begin
                state_next.phase = 1'b0;
            end
            if (state_reg.settle != 2'h0) begin
                state_next.settle = state_reg.settle - 2'h1;
            end else begin
                state_next.result = coded;
                state_next.ready_n = 1'b0;
            end
        end
        // One idle cycle with both clocks low keeps the phases nonoverlapping.
        state_next.exc_a = config_i.ac_mode && !state_next.phase && !state_reg.exc_b;
        state_next.exc_b = config_i.ac_mode && state_next.phase && !state_reg.exc_a;
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg.sync1 <= SYNC_RESET;
            state_reg.sync2 <= SYNC_RESET;
            state_reg.ref_missing <= 1'b0;
            state_reg.channel <= 2'h0;
            state_reg.settle <= SETTLE_SAMPLES;
            state_reg.ready_n <= 1'b1;
            state_reg.result <= '0;
            state_reg.phase <= 1'b0;
            state_reg.exc_a <= 1'b0;
            state_reg.exc_b <= 1'b0;
            state_reg.burn_src <= 1'b0;
            state_reg.burn_snk <= 1'b0;
            state_reg.dac <= DAC_RESET;
            state_reg.gain <= GAIN_RESET;
            state_reg.range_mv <= BASE_RANGE_MV;
            state_reg.high_ref <= 1'b0;
            state_reg.step_uv <= DAC_STEP_LOW_UV;
        end else begin
            state_reg <= state_next;
        end
    end

    assign result_o = state_reg.result;
    assign ready_n_o = state_reg.ready_n;
    assign ref_missing_o = state_reg.ref_missing;
    assign channel_o = state_reg.channel;
    assign gain_o = state_reg.gain;
    assign range_mv_o = state_reg.range_mv;
    assign dac_o = state_reg.dac;
    assign dac_step_uv_o = state_reg.step_uv;
    assign burnout_source_o = state_reg.burn_src;
    assign burnout_sink_o = state_reg.burn_snk;
    assign high_reference_select_o = state_reg.high_ref;
    assign excitation_clock_o = state_reg.exc_a;
    assign excitation_clock_n_o = state_reg.exc_b;

endmodule // bac_input_control

// ---- design/bac_pkg.sv ----
// Purpose: Shared constants and carriers for the bridge converter input control, plus the result coder.
// Assumes: Filtered samples arrive as signed 24-bit values scaled to the selected range.
// Notes: The coder is purely combinational; the top registers its output.
`timescale 1ns/1ps

package bac_pkg;

    localparam int SAMPLE_W = 24;
    localparam int NARROW_W = 16;
    localparam logic [1:0] SETTLE_SAMPLES = 2'h3;
    localparam logic [11:0] DAC_STEP_LOW_UV = 12'h4E2;
    localparam logic [11:0] DAC_STEP_HIGH_UV = 12'h9C4;
    localparam logic [6:0] BASE_RANGE_MV = 7'h0A;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic [5:0] DAC_RESET = 6'h00;
    localparam logic [1:0] GAIN_RESET = 2'h0;

    typedef struct packed {
        logic sign;
        logic [4:0] magnitude;
    } bac_dac_type;

    typedef struct packed {
        logic [1:0] channel;
        logic bipolar;
        logic [1:0] gain;
        bac_dac_type dac;
        logic burnout_enable;
        logic high_reference_select;
        logic ac_mode;
        logic wide_word;
    } bac_config_type;

    typedef struct packed {
        logic ref_low;
        logic ref_open_pos;
        logic ref_open_neg;
    } bac_ref_type;

endpackage

module bac_coder import bac_pkg::*; (
    input wire logic signed [SAMPLE_W-1:0] sample_i, // Signed filtered sample.
    input wire logic bipolar_i, // High selects offset binary.
    input wire logic wide_i, // High selects the full word width.
    input wire logic force_ones_i, // High forces an all-ones result.
    output logic [SAMPLE_W-1:0] code_o // Coded result, narrow words in the low bits.
);

    logic [SAMPLE_W-1:0] full_code;

    always_comb begin
        if (bipolar_i) begin
            full_code = {~sample_i[SAMPLE_W-1], sample_i[SAMPLE_W-2:0]};
        end else if (sample_i[SAMPLE_W-1]) begin
            full_code = '0;
        end else if (&sample_i[SAMPLE_W-2:0]) begin
            full_code = '1;
        end else begin
            full_code = {sample_i[SAMPLE_W-2:0], 1'b0};
        end
        if (force_ones_i) begin
            full_code = '1;
        end
        if (wide_i) begin
            code_o = full_code;
        end else begin
            code_o = {{(SAMPLE_W-NARROW_W){1'b0}}, full_code[SAMPLE_W-1 -: NARROW_W]};
        end
    end

endmodule // bac_coder

// ---- verification/bac_input_control_assertions.sv ----
// Purpose: Port-level checker for the bridge converter input control.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module bac_input_control_assertions import bac_pkg::*; (
    input wire logic clk_sys_i, // Clock.
    input wire logic rst_n_i, // Reset.
    input wire bac_config_type config_i, // Settings.
    input wire bac_ref_type ref_detect_i, // Reference pins.
    input wire logic sample_valid_i, // Sample pulse.
    input wire logic result_read_i, // Host read pulse.
    input wire logic [SAMPLE_W-1:0] result_o, // Result.
    input wire logic ready_n_o, // Ready, low active.
    input wire logic ref_missing_o, // Reference flag.
    input wire logic [1:0] channel_o, // Channel.
    input wire logic [11:0] dac_step_uv_o, // DAC step.
    input wire logic burnout_source_o, // Source switch.
    input wire logic burnout_sink_o, // Sink switch.
    input wire logic high_reference_select_o, // Reference range.
    input wire logic excitation_clock_o, // Phase A.
    input wire logic excitation_clock_n_o // Phase B.
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_switch;
        channel_o != $past(channel_o);
    endsequence
    sequence s_hold;
        ready_n_o [*4];
    endsequence
    a_burnout_pair: assert property (burnout_source_o == burnout_sink_o)
        else $error("burnout switches differ");
    a_burnout_follow: assert property (##1 burnout_source_o == $past(config_i.burnout_enable))
        else $error("burnout switch does not follow setting");
    a_step_size: assert property (dac_step_uv_o == (high_reference_select_o ? DAC_STEP_HIGH_UV : DAC_STEP_LOW_UV))
        else $error("offset step size wrong");
    a_settle_hold: assert property (s_switch |-> s_hold)
        else $error("ready shown too early after channel change");
    a_read_clears: assert property (result_read_i && !sample_valid_i && !$past(sample_valid_i) |=> ready_n_o)
        else $error("ready stays after read");
    a_missing_ones: assert property ($fell(ready_n_o) && ref_missing_o && $past(ref_missing_o) && $past(ref_missing_o, 2)
        |-> (&result_o[15:0]) && (!$past(config_i.wide_word) || &result_o[23:16]))
        else $error("result not all ones without reference");
    a_missing_flag: assert property ($stable(ref_detect_i) [*4] |-> ref_missing_o == |ref_detect_i)
        else $error("reference flag wrong");
    a_exc_overlap: assert property (!(excitation_clock_o && excitation_clock_n_o))
        else $error("excitation phases overlap");
endmodule // bac_input_control_assertions

bind bac_input_control bac_input_control_assertions u_chk (.clk_sys_i, .rst_n_i, .config_i, .ref_detect_i,
    .sample_valid_i, .result_read_i, .result_o, .ready_n_o, .ref_missing_o, .channel_o, .dac_step_uv_o,
    .burnout_source_o, .burnout_sink_o, .high_reference_select_o, .excitation_clock_o, .excitation_clock_n_o);

// ---- verification/bac_host_model.sv ----
// Purpose: Host model that reads each settled result.
// Assumes: Read pulses last one cycle and change at the falling edge.
// Notes: Looks at the reference flag only when the low 16 result bits are all ones.
`timescale 1ns/1ps
module bac_host_model import bac_pkg::*; (
    input wire logic clk_sys_i, // Clock.
    input wire logic fetch_i, // High lets the host read.
    input wire logic ready_n_i, // Ready, low active.
    input wire logic [SAMPLE_W-1:0] result_i, // Result.
    input wire logic ref_missing_i, // Reference flag.
    output logic result_read_o = 1'b0, // Read pulse.
    output logic [SAMPLE_W-1:0] got_o = 24'h0, // Last result read.
    output logic flag_o = 1'b0 // Flag seen with all ones.
);
    always @(negedge clk_sys_i) begin
        result_read_o <= fetch_i && !ready_n_i && !result_read_o;
        if (fetch_i && !ready_n_i && !result_read_o) begin
            got_o <= result_i;
            flag_o <= (&result_i[15:0]) && ref_missing_i;
        end
    end
endmodule // bac_host_model

// ---- verification/bac_input_control_bench.sv ----
// Purpose: Self-checking bench for the bridge converter input control.
// Assumes: Inputs change at the falling edge.
// Notes: The host model performs every result read.
`timescale 1ns/1ps
module bac_input_control_bench import bac_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    bac_config_type cfg = '0;
    bac_ref_type pins = 3'h0;
    logic signed [SAMPLE_W-1:0] smp = 24'h0;
    logic vld = 1'b0;
    logic rd, rdy_n, miss, flag, src, snk, hr, ea, eb;
    logic [SAMPLE_W-1:0] res, got;
    logic [1:0] ch, gn;
    logic [6:0] rng;
    logic [11:0] stp;
    bac_dac_type dac;
    int mismatches = 0;
    int n_checks = 0;
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    bac_input_control u_dut (.clk_sys_i, .rst_n_i, .config_i(cfg), .ref_detect_i(pins), .sample_i(smp),
        .sample_valid_i(vld), .result_read_i(rd), .result_o(res), .ready_n_o(rdy_n), .ref_missing_o(miss),
        .channel_o(ch), .gain_o(gn), .range_mv_o(rng), .dac_o(dac), .dac_step_uv_o(stp), .burnout_source_o(src),
        .burnout_sink_o(snk), .high_reference_select_o(hr), .excitation_clock_o(ea), .excitation_clock_n_o(eb));
    bac_host_model u_host (.clk_sys_i, .fetch_i(1'b1), .ready_n_i(rdy_n), .result_i(res),
        .ref_missing_i(miss), .result_read_o(rd), .got_o(got), .flag_o(flag));
    task automatic check(input string w, input logic [SAMPLE_W-1:0] s, input logic [SAMPLE_W-1:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic pulse();
        @(negedge clk_sys_i);
        vld = 1'b1;
        @(negedge clk_sys_i);
        vld = 1'b0;
    endtask
    task automatic conv(input logic [SAMPLE_W-1:0] s, input logic [SAMPLE_W-1:0] e);
        smp = s;
        pulse();
        for (int i = 0; i < 8 && rd !== 1'b1; i++) @(posedge clk_sys_i);
        if (rd !== 1'b1) begin
            mismatches++;
            results();
        end
        // Return on a falling edge so the caller's next input change stays off the sampling edge.
        @(negedge clk_sys_i);
        check("result", got, e);
    endtask
    task automatic skip3();
        repeat (3) begin
            pulse();
            check("ready_n", 24'(rdy_n), 24'h1);
        end
    endtask
    initial begin
        cfg.wide_word = 1'b1;
        repeat (15) @(negedge clk_sys_i);
        check("step", 24'(stp), 24'(DAC_STEP_LOW_UV));
        check("range", 24'(rng), 24'h00000A);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        skip3();
        conv(24'h000000, 24'h000000);
        conv(24'h400000, 24'h800000);
        conv(24'h7FFFFF, 24'hFFFFFF);
        cfg.bipolar = 1'b1;
        conv(24'h800000, 24'h000000);
        conv(24'h000000, 24'h800000);
        conv(24'h7FFFFF, 24'hFFFFFF);
        cfg.wide_word = 1'b0;
        conv(24'h000000, 24'h008000);
        conv(24'h7FFFFF, 24'h00FFFF);
        $display("test coding done");
        @(negedge clk_sys_i);
        cfg.channel = 2'h1;
        cfg.gain = 2'h3;
        cfg.burnout_enable = 1'b1;
        cfg.high_reference_select = 1'b1;
        cfg.dac = 6'h3F;
        @(negedge clk_sys_i);
        check("channel", 24'(ch), 24'h1);
        check("range", 24'(rng), 24'h000050);
        check("burnout", 24'({src, snk}), 24'h3);
        check("step", 24'(stp), 24'(DAC_STEP_HIGH_UV));
        check("dac", 24'(dac), 24'h3F);
        check("gain", 24'(gn), 24'h3);
        check("high_ref", 24'(hr), 24'h1);
        skip3();
        conv(24'h800000, 24'h000000);
        cfg.burnout_enable = 1'b0;
        @(negedge clk_sys_i);
        check("burnout", 24'({src, snk}), 24'h0);
        $display("test config done");
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_sys_i);
            pins = bac_ref_type'(3'h1 << i);
            repeat (4) @(negedge clk_sys_i);
            check("ref_missing", 24'(miss), 24'h1);
            conv(24'h000000, 24'h00FFFF);
            check("host_flag", 24'(flag), 24'h1);
            @(negedge clk_sys_i);
            pins = 3'h0;
            repeat (4) @(negedge clk_sys_i);
            check("ref_missing", 24'(miss), 24'h0);
            conv(24'h000000, 24'h008000);
            check("host_flag", 24'(flag), 24'h0);
        end
        $display("test reference done");
        cfg.ac_mode = 1'b1;
        cfg.bipolar = 1'b0;
        cfg.wide_word = 1'b1;
        conv(24'h400000, 24'h800000);
        check("excitation", 24'({ea, eb}), 24'h1);
        conv(24'h400000, 24'h000000);
        check("excitation", 24'({ea, eb}), 24'h2);
        cfg.ac_mode = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check("excitation", 24'({ea, eb}), 24'h0);
        $display("test ac done");
        results();
    end
endmodule // bac_input_control_bench
